// ---- rsq_core.sv ----
// Working registers and instruction sequencing counter of the processor.
// Assumes control logic, memory, tape and drum run on ref_clk_in and present
// orders and words on the same clock, so no input is synchronised.
`timescale 1ns/1ps
`default_nettype none
module rsq_core
  import rsq_pkg::*;
(
  // Clock and reset
  input  wire logic               ref_clk_in,
  input  wire logic               srst_in,
  // Operator controls
  input  wire logic               man_set_in,
  input  wire logic [ADDR_W-1:0]  man_addr_in,
  input  wire logic               start_in,
  input  wire logic               load_start_in,
  // Order port
  input  wire logic               cmd_valid_in,
  input  wire logic [4:0]         cmd_op_in,
  input  wire logic [ADDR_W-1:0]  cmd_addr_in,
  input  wire logic [WORD_W-1:0]  cmd_word_in,
  input  wire logic [WORD_W-1:0]  cmd_result_in,
  input  wire logic [WORD_W-1:0]  cmd_low_in,
  input  wire logic               cmd_cond_in,
  input  wire logic               cmd_sum_in,
  output logic                    cmd_ready_out,
  // Tape and drum word stream
  input  wire logic               xfer_valid_in,
  input  wire logic [WORD_W-1:0]  xfer_word_in,
  input  wire logic               xfer_last_in,
  // Memory write port
  output logic                    mem_we_out,
  output logic [ADDR_W-1:0]       mem_addr_out,
  output logic [WORD_W-1:0]       mem_wdata_out,
  // Visible state
  output logic [WORD_W-1:0]       ihr_out,
  output logic [WORD_W-1:0]       mbr_out,
  output logic [WORD_W-1:0]       lpr_out,
  output logic [WORD_W-1:0]       lpa_out,
  output logic [WORD_W-1:0]       acc_out,
  output logic [WORD_W-1:0]       acca_out,
  output logic [ADDR_W-1:0]       counter_out,
  output logic                    loading_out,
  output logic                    busy_out,
  output logic                    halted_out
);

  rsq_state_t            state_r, state_nxt;
  logic [WORD_W-1:0]     ihr_r, ihr_nxt;
  logic [WORD_W-1:0]     mbr_r, mbr_nxt;
  logic [WORD_W-1:0]     lpr_r, lpr_nxt;
  logic [WORD_W-1:0]     lpa_r, lpa_nxt;
  logic [WORD_W-1:0]     acc_r, acc_nxt;
  logic [WORD_W-1:0]     acca_r, acca_nxt;
  logic [ADDR_W-1:0]     cnt_r, cnt_nxt;
  logic [ADDR_W-1:0]     init_r, init_nxt;
  logic [DRUM_CNT_W-1:0] dcnt_r, dcnt_nxt;
  logic                  drum_r, drum_nxt;
  logic                  sum_r, sum_nxt;
  logic                  halted_r, halted_nxt;
  logic                  we_r, we_nxt;
  logic [ADDR_W-1:0]     waddr_r, waddr_nxt;
  logic [WORD_W-1:0]     wdata_r, wdata_nxt;
  logic                  take;
  logic                  drum_done;
  rsq_op_t               op;
  logic [WORD_W-1:0]     addr_word;
  logic [WORD_W-1:0]     acc_add;

  rsq_shift_if sh ();

  rsq_aux_shift u_shift (
    .sh (sh)
  );

  assign op        = rsq_op_t'(cmd_op_in);
  assign take      = cmd_valid_in && cmd_ready_out;
  assign addr_word = {{ADDR_PAD{1'b0}}, cmd_addr_in};
  assign acc_add   = acc_r + addr_word;
  assign drum_done = (state_r == ST_XFER_IN || state_r == ST_XFER_OUT) && drum_r
                     && xfer_valid_in && dcnt_r == DRUM_LAST;

  // Orders are held off while a stream runs or the machine is halted
  assign cmd_ready_out = (state_r == ST_RUN) && !halted_r;

  // Shifter sees the values about to be registered, so auxiliaries track them
  assign sh.acc_val = acc_nxt;
  assign sh.low_val = lpr_nxt;

  always_comb begin
    state_nxt  = state_r;
    ihr_nxt    = ihr_r;
    mbr_nxt    = mbr_r;
    lpr_nxt    = lpr_r;
    lpa_nxt    = lpa_r;
    acc_nxt    = acc_r;
    acca_nxt   = acca_r;
    cnt_nxt    = cnt_r;
    init_nxt   = init_r;
    dcnt_nxt   = dcnt_r;
    drum_nxt   = drum_r;
    sum_nxt    = sum_r;
    halted_nxt = halted_r;
    we_nxt     = 1'b0;
    waddr_nxt  = waddr_r;
    wdata_nxt  = wdata_r;
    unique case (state_r)
      ST_RUN: begin
        if (man_set_in) begin
          cnt_nxt = man_addr_in;
        end
        if (start_in) begin
          halted_nxt = 1'b0;
        end
        if (load_start_in && !halted_r) begin
          state_nxt = ST_LOAD;
          init_nxt  = cnt_r;
          ihr_nxt   = WORD_RST;
          acc_nxt   = WORD_RST;
          acca_nxt  = sh.acc_left;
        end else if (take) begin
          unique case (op)
            OP_FETCH: begin
              ihr_nxt = cmd_word_in;
              cnt_nxt = cnt_r + 12'h001;
            end
            OP_OPERAND: begin
              mbr_nxt  = cmd_word_in;
              acc_nxt  = cmd_result_in;
              acca_nxt = sh.acc_left;
            end
            OP_LOAD_LOW: begin
              mbr_nxt = cmd_word_in;
              lpr_nxt = cmd_word_in;
            end
            OP_STORE_LOW: begin
              mbr_nxt   = lpr_r;
              we_nxt    = 1'b1;
              waddr_nxt = cmd_addr_in;
              wdata_nxt = lpr_r;
            end
            OP_ADD_ADDR_CLR, OP_ADD_ADDR_HELD: begin
              mbr_nxt  = addr_word;
              acc_nxt  = (op == OP_ADD_ADDR_CLR) ? addr_word : acc_add;
              acca_nxt = sh.acc_left;
            end
            OP_READ: begin
              mbr_nxt   = cmd_word_in;
              we_nxt    = 1'b1;
              waddr_nxt = cmd_addr_in;
              wdata_nxt = cmd_word_in;
            end
            OP_SUBST: begin
              mbr_nxt   = cmd_word_in;
              we_nxt    = 1'b1;
              waddr_nxt = cmd_addr_in;
              wdata_nxt = {cmd_word_in[WORD_W-1:ADDR_W], acc_r[ADDR_HI:ADDR_LO]};
            end
            OP_STORE_ACC: begin
              we_nxt    = 1'b1;
              waddr_nxt = cmd_addr_in;
              wdata_nxt = acc_r;
            end
            OP_MUL, OP_RSHIFT, OP_DIV, OP_LSHIFT: begin
              acc_nxt  = cmd_result_in;
              lpr_nxt  = cmd_low_in;
              lpa_nxt  = (op == OP_MUL || op == OP_RSHIFT) ? sh.low_left : sh.low_right;
              acca_nxt = (op == OP_MUL || op == OP_RSHIFT) ? sh.acc_left : sh.acc_right;
            end
            OP_PRINT_SYNC: begin
              acc_nxt = WORD_ONES;
            end
            OP_JUMP, OP_JUMP_COND: begin
              if (op == OP_JUMP || cmd_cond_in) begin
                cnt_nxt = cmd_addr_in;
              end
            end
            OP_INVALID: begin
              halted_nxt = 1'b1;
            end
            OP_TAPE_IN, OP_DRUM_IN, OP_TAPE_OUT, OP_DRUM_OUT: begin
              state_nxt = (op == OP_TAPE_IN || op == OP_DRUM_IN) ? ST_XFER_IN : ST_XFER_OUT;
              drum_nxt  = (op == OP_DRUM_IN || op == OP_DRUM_OUT);
              sum_nxt   = (op == OP_DRUM_IN) && cmd_sum_in;
              cnt_nxt   = cmd_addr_in;
              dcnt_nxt  = '0;
              if (op == OP_DRUM_IN && cmd_sum_in) begin
                acc_nxt  = WORD_RST;
                acca_nxt = sh.acc_left;
              end
            end
            default: begin
              halted_nxt = 1'b1;
            end
          endcase
        end
      end
      ST_LOAD: begin
        ihr_nxt = WORD_RST;
        if (xfer_valid_in) begin
          mbr_nxt   = xfer_word_in;
          we_nxt    = 1'b1;
          waddr_nxt = cnt_r;
          wdata_nxt = xfer_word_in;
          acc_nxt   = acc_r + xfer_word_in;
          acca_nxt  = sh.acc_left;
          cnt_nxt   = cnt_r + 12'h001;
          if (xfer_last_in) begin
            cnt_nxt   = init_r;
            state_nxt = ST_RUN;
          end
        end
      end
      ST_XFER_IN, ST_XFER_OUT: begin
        if (xfer_valid_in) begin
          mbr_nxt  = xfer_word_in;
          cnt_nxt  = cnt_r + 12'h001;
          dcnt_nxt = dcnt_r + 6'h01;
          if (state_r == ST_XFER_IN) begin
            lpr_nxt   = xfer_word_in;
            lpa_nxt   = sh.low_right;
            we_nxt    = 1'b1;
            waddr_nxt = cnt_r;
            wdata_nxt = xfer_word_in;
          end
          // Only a summing drum input sets sum_r, so output streams never touch the accumulator
          if (sum_r) begin
            acc_nxt  = acc_r + xfer_word_in;
            acca_nxt = sh.acc_left;
          end
          if (drum_done) begin
            cnt_nxt   = ihr_r[RET_HI:RET_LO];
            state_nxt = ST_RUN;
          end else if (!drum_r && xfer_last_in) begin
            state_nxt = ST_RUN;
          end
        end
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  // Low product and its auxiliary are deliberately kept out of ST_LOAD above
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      state_r  <= ST_RUN;
      ihr_r    <= WORD_RST;
      mbr_r    <= WORD_RST;
      lpr_r    <= WORD_RST;
      lpa_r    <= WORD_RST;
      acc_r    <= WORD_RST;
      acca_r   <= WORD_RST;
      cnt_r    <= ADDR_RST;
      init_r   <= ADDR_RST;
      dcnt_r   <= '0;
      drum_r   <= 1'b0;
      sum_r    <= 1'b0;
      halted_r <= 1'b0;
      we_r     <= 1'b0;
      waddr_r  <= ADDR_RST;
      wdata_r  <= WORD_RST;
    end else begin
      state_r  <= state_nxt;
      ihr_r    <= ihr_nxt;
      mbr_r    <= mbr_nxt;
      lpr_r    <= lpr_nxt;
      lpa_r    <= lpa_nxt;
      acc_r    <= acc_nxt;
      acca_r   <= acca_nxt;
      cnt_r    <= cnt_nxt;
      init_r   <= init_nxt;
      dcnt_r   <= dcnt_nxt;
      drum_r   <= drum_nxt;
      sum_r    <= sum_nxt;
      halted_r <= halted_nxt;
      we_r     <= we_nxt;
      waddr_r  <= waddr_nxt;
      wdata_r  <= wdata_nxt;
    end
  end

  assign ihr_out       = ihr_r;
  assign mbr_out       = mbr_r;
  assign lpr_out       = lpr_r;
  assign lpa_out       = lpa_r;
  assign acc_out       = acc_r;
  assign acca_out      = acca_r;
  assign counter_out   = cnt_r;
  assign loading_out   = (state_r == ST_LOAD);
  assign busy_out      = (state_r != ST_RUN);
  assign halted_out    = halted_r;
  assign mem_we_out    = we_r;
  assign mem_addr_out  = waddr_r;
  assign mem_wdata_out = wdata_r;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (srst_in);

  sequence fetch_taken;
    take && op == OP_FETCH;
  endsequence

  sequence drum_end;
    drum_done;
  endsequence

  load_zero_a: assert property (state_r == ST_LOAD |-> ihr_r == WORD_RST)
    else $error("instruction register not zero during load");
  fetch_hold_a: assert property (fetch_taken |=> ihr_r == $past(cmd_word_in))
    else $error("fetched word not held");
  fetch_step_a: assert property (fetch_taken |=> cnt_r == $past(cnt_r) + 12'h001)
    else $error("counter did not step on fetch");
  halt_addr_a: assert property (fetch_taken ##1 (take && op == OP_INVALID)
                                |=> halted_r && cnt_r == $past(cnt_r, 2) + 12'h001)
    else $error("halt address does not locate invalid word");
  store_low_a: assert property (take && op == OP_STORE_LOW |=> mbr_r == lpr_r && we_r)
    else $error("buffer differs from low product after store");
  store_acc_a: assert property (take && op == OP_STORE_ACC |=> $stable(mbr_r))
    else $error("buffer changed by accumulator store");
  load_low_a: assert property (state_r == ST_LOAD |=> $stable(lpr_r) && $stable(lpa_r))
    else $error("low product changed by load");
  mul_aux_a: assert property (take && (op == OP_MUL || op == OP_RSHIFT)
                              |=> lpa_r[WORD_W-1:1] == lpr_r[WORD_W-2:0])
    else $error("low auxiliary not displaced left");
  print_ones_a: assert property (take && op == OP_PRINT_SYNC |=> acc_r == WORD_ONES)
    else $error("accumulator not all ones after print sync");
  jump_load_a: assert property (take && op == OP_JUMP |=> cnt_r == $past(cmd_addr_in))
    else $error("transfer did not load counter");
  drum_ret_a: assert property (drum_end |=> cnt_r == ihr_r[RET_HI:RET_LO] && state_r == ST_RUN)
    else $error("drum order did not restore counter");
  load_ret_a: assert property (state_r == ST_LOAD && xfer_valid_in && xfer_last_in
                               |=> cnt_r == $past(init_r) && state_r == ST_RUN)
    else $error("load did not return to initial address");

endmodule
`default_nettype wire

// ---- rsq_pkg.sv ----
// Shared constants and order codes for the register and sequencer state block.
// Assumes one 50 MHz clock and a 40-bit word with a 12-bit address field.
package rsq_pkg;

  // Word and address geometry
  localparam int WORD_W     = 40;
  localparam int ADDR_W     = 12;
  localparam int ADDR_PAD   = WORD_W - ADDR_W;
  localparam int SIGN_BIT   = 39;
  localparam int ADDR_LO    = 0;
  localparam int ADDR_HI    = 11;
  localparam int RET_LO     = 28;
  localparam int RET_HI     = 39;
  localparam int TAPE_BLOCK = 1024;

  // Drum transfer length
  localparam int DRUM_CNT_W                 = 6;
  localparam logic [DRUM_CNT_W-1:0] DRUM_LAST = 6'h31;  // Fiftieth word, counted from zero

  // Reset and all-ones values
  localparam logic [WORD_W-1:0] WORD_RST  = 40'h00_0000_0000;
  localparam logic [WORD_W-1:0] WORD_ONES = 40'hff_ffff_ffff;
  localparam logic [ADDR_W-1:0] ADDR_RST  = 12'h000;

  // Orders presented on the command port
  typedef enum logic [4:0] {
    OP_FETCH,
    OP_OPERAND,
    OP_LOAD_LOW,
    OP_STORE_LOW,
    OP_ADD_ADDR_CLR,
    OP_ADD_ADDR_HELD,
    OP_READ,
    OP_SUBST,
    OP_STORE_ACC,
    OP_MUL,
    OP_RSHIFT,
    OP_DIV,
    OP_LSHIFT,
    OP_PRINT_SYNC,
    OP_JUMP,
    OP_JUMP_COND,
    OP_INVALID,
    OP_TAPE_IN,
    OP_DRUM_IN,
    OP_TAPE_OUT,
    OP_DRUM_OUT
  } rsq_op_t;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_RUN,
    ST_LOAD,
    ST_XFER_IN,
    ST_XFER_OUT
  } rsq_state_t;

endpackage

// ---- rsq_shift_if.sv ----
// Carrier between the sequencer and its one-place shifter.
// Assumes both ends sit on the same clock; the shifter is purely combinational.
`timescale 1ns/1ps
`default_nettype none
interface rsq_shift_if;
  import rsq_pkg::*;
  logic [WORD_W-1:0] acc_val;
  logic [WORD_W-1:0] low_val;
  logic [WORD_W-1:0] acc_left;
  logic [WORD_W-1:0] acc_right;
  logic [WORD_W-1:0] low_left;
  logic [WORD_W-1:0] low_right;

  modport user (output acc_val, output low_val,
                input acc_left, input acc_right, input low_left, input low_right);
  modport unit (input acc_val, input low_val,
                output acc_left, output acc_right, output low_left, output low_right);
endinterface
`default_nettype wire

// ---- rsq_aux_shift.sv ----
// One-place displacement used to form the auxiliary register contents.
// Assumes values on the carrier are stable within a cycle.
`timescale 1ns/1ps
`default_nettype none
module rsq_aux_shift
  import rsq_pkg::*;
(
  rsq_shift_if.unit sh
);

  // Right displacement keeps the sign in the sign place; left displacement moves bit 38 into the sign place
  assign sh.acc_left  = {sh.acc_val[WORD_W-2:0], 1'b0};
  assign sh.acc_right = {sh.acc_val[SIGN_BIT], sh.acc_val[WORD_W-1:1]};
  assign sh.low_left  = {sh.low_val[WORD_W-2:0], 1'b0};
  assign sh.low_right = {sh.low_val[SIGN_BIT], sh.low_val[WORD_W-1:1]};

endmodule
`default_nettype wire

// ---- rsq_mem_model.sv ----
// Main memory with a tape or drum word source for the register and sequencer block.
// Assumes the bench pulses go_in together with the order that opens a stream.
`timescale 1ns/1ps
`default_nettype none
module rsq_mem_model
  import rsq_pkg::*;
(
  // Clock
  input  wire logic              ref_clk_in,
  // Memory write port
  input  wire logic              mem_we_in,
  input  wire logic [ADDR_W-1:0] mem_addr_in,
  input  wire logic [WORD_W-1:0] mem_wdata_in,
  // Stream request
  input  wire logic              go_in,
  input  wire logic [6:0]        count_in,
  input  wire logic [WORD_W-1:0] base_in,
  // Word stream
  output logic                   xfer_valid_out,
  output logic [WORD_W-1:0]      xfer_word_out,
  output logic                   xfer_last_out
);
  logic [WORD_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [6:0]        left_r = 7'h00;
  logic [6:0]        idx_r  = 7'h00;
  logic              vld_r  = 1'b0;
  logic              last_r = 1'b0;
  logic [WORD_W-1:0] word_r = 40'h0;
  assign xfer_valid_out = vld_r;
  assign xfer_word_out  = word_r;
  assign xfer_last_out  = last_r;
  always @(posedge ref_clk_in) begin
    if (mem_we_in)
      mem[mem_addr_in] <= mem_wdata_in;
    if (go_in) begin
      left_r <= count_in - 7'h01;
      idx_r  <= 7'h01;
      vld_r  <= 1'b1;
      word_r <= base_in;
      last_r <= (count_in == 7'h01);
    end else if (left_r != 7'h00) begin
      left_r <= left_r - 7'h01;
      idx_r  <= idx_r + 7'h01;
      vld_r  <= 1'b1;
      word_r <= base_in + 40'(idx_r);
      last_r <= (left_r == 7'h01);
    end else begin
      // Released line shows the inverse of the last word, flipping back to it on each idle cycle
      vld_r  <= 1'b0;
      word_r <= ~word_r;
      last_r <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- tb_rsq_core.sv ----
// Self-checking bench for rsq_core: orders, operator controls, load and drum streams.
// Assumes rsq_mem_model stands in for memory, tape and drum.
`timescale 1ns/1ps
`default_nettype none
module tb_rsq_core;
  import rsq_pkg::*;
  logic              clk = 1'b0;
  logic              srst = 1'b1, mset = 1'b0, start = 1'b0, lstart = 1'b0;
  logic              cv = 1'b0, cond = 1'b0, sum = 1'b0, go = 1'b0;
  logic [4:0]        op = 5'h00;
  logic [6:0]        cnt = 7'h00;
  logic [ADDR_W-1:0] maddr = 12'h000, ad = 12'h000;
  logic [WORD_W-1:0] wd = 40'h0, rs = 40'h0, lw = 40'h0, base = 40'h0;
  logic              xv, xl, ready, we, loading, busy, halted;
  logic [ADDR_W-1:0] ma, ctr;
  logic [WORD_W-1:0] xw, wdat, ihr, mbr, lpr, lpa, acc, acca;
  int                n_fail = 0, total_checks = 0;
  localparam logic [WORD_W-1:0] W1 = 40'h3a_5012_3456;
  localparam logic [WORD_W-1:0] L2 = 40'h81_2345_6789;
  always #10 clk = ~clk;

  rsq_core u_rsq_core (.ref_clk_in(clk), .srst_in(srst), .man_set_in(mset), .man_addr_in(maddr),
    .start_in(start), .load_start_in(lstart), .cmd_valid_in(cv), .cmd_op_in(op), .cmd_addr_in(ad),
    .cmd_word_in(wd), .cmd_result_in(rs), .cmd_low_in(lw), .cmd_cond_in(cond), .cmd_sum_in(sum),
    .cmd_ready_out(ready), .xfer_valid_in(xv), .xfer_word_in(xw), .xfer_last_in(xl),
    .mem_we_out(we), .mem_addr_out(ma), .mem_wdata_out(wdat), .ihr_out(ihr), .mbr_out(mbr),
    .lpr_out(lpr), .lpa_out(lpa), .acc_out(acc), .acca_out(acca), .counter_out(ctr),
    .loading_out(loading), .busy_out(busy), .halted_out(halted));
  rsq_mem_model u_rsq_mem_model (.ref_clk_in(clk), .mem_we_in(we), .mem_addr_in(ma),
    .mem_wdata_in(wdat), .go_in(go), .count_in(cnt), .base_in(base), .xfer_valid_out(xv),
    .xfer_word_out(xw), .xfer_last_out(xl));

  function automatic logic [WORD_W-1:0] lsh(input logic [WORD_W-1:0] v);
    return {v[38:0], 1'b0};
  endfunction
  function automatic logic [WORD_W-1:0] rsh(input logic [WORD_W-1:0] v);
    return {v[39], v[39:1]};
  endfunction
  task automatic give_verdict;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic do_op(input rsq_op_t o, input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] w, r, l);
    @(posedge clk);
    cv <= 1'b1; op <= o; ad <= a; wd <= w; rs <= r; lw <= l;
    @(posedge clk);
    cv <= 1'b0;
    #1;
  endtask
  // Two orders on consecutive edges, valid held high between them
  task automatic do_pair(input rsq_op_t o1, input logic [WORD_W-1:0] w1, input rsq_op_t o2);
    @(posedge clk);
    cv <= 1'b1; op <= o1; wd <= w1;
    @(posedge clk);
    op <= o2;
    @(posedge clk);
    cv <= 1'b0;
    #1;
  endtask
  task automatic pulse_ctl(input int which, input logic [ADDR_W-1:0] a);
    @(posedge clk);
    if (which == 0) begin
      mset <= 1'b1; maddr <= a;
    end else
      start <= 1'b1;
    @(posedge clk);
    mset <= 1'b0; start <= 1'b0;
    #1;
  endtask
  task automatic stream(input logic ld, input rsq_op_t o, input logic [ADDR_W-1:0] a,
                        input logic [6:0] n, input logic [WORD_W-1:0] b);
    @(posedge clk);
    lstart <= ld; cv <= ~ld; op <= o; ad <= a; go <= 1'b1; cnt <= n; base <= b;
    @(posedge clk);
    lstart <= 1'b0; cv <= 1'b0; go <= 1'b0;
    #1;
  endtask
  task automatic wait_idle;
    int i;
    for (i = 0; i < 200; i++) begin
      @(posedge clk);
      #1;
      if (busy === 1'b0) begin
        repeat (2) @(posedge clk);
        #1;
        return;
      end
    end
    n_fail++;
    give_verdict();
  endtask

  task automatic t_reset;
    check(40'(ready), 40'h1);
    check(40'(ctr), 40'h0);
    check(acc | mbr | ihr | lpr, 40'h0);
  endtask
  task automatic t_fetch;
    pulse_ctl(0, 12'h020);
    check(40'(ctr), 40'h020);
    do_pair(OP_FETCH, W1, OP_INVALID);
    check(ihr, W1);
    check(40'(ctr), 40'h021);
    check(40'(halted), 40'h1);
    check(40'(ctr - 12'h001), 40'h020);
    do_op(OP_FETCH, 12'h000, 40'h5, 40'h0, 40'h0);
    check(ihr, W1);
    pulse_ctl(1, 12'h000);
    check(40'(ready), 40'h1);
  endtask
  task automatic t_arith;
    rsq_op_t sops [4];
    int      i;
    sops = '{OP_MUL, OP_RSHIFT, OP_DIV, OP_LSHIFT};
    do_op(OP_LOAD_LOW, 12'h000, 40'h12_0000_0034, 40'h0, 40'h0);
    check(lpr, 40'h12_0000_0034);
    do_op(OP_STORE_LOW, 12'h050, 40'h0, 40'h0, 40'h0);
    check(mbr, 40'h12_0000_0034);
    do_op(OP_READ, 12'h051, 40'h66_7788_99aa, 40'h0, 40'h0);
    check(mbr, 40'h66_7788_99aa);
    check(u_rsq_mem_model.mem[12'h050], 40'h12_0000_0034);
    do_op(OP_OPERAND, 12'h052, 40'h0a_0b0c_0d0e, 40'h40_0000_0003, 40'h0);
    check(mbr, 40'h0a_0b0c_0d0e);
    check(acca, lsh(40'h40_0000_0003));
    check(u_rsq_mem_model.mem[12'h051], 40'h66_7788_99aa);
    do_op(OP_STORE_ACC, 12'h053, 40'h0, 40'h0, 40'h0);
    check(mbr, 40'h0a_0b0c_0d0e);
    do_op(OP_ADD_ADDR_CLR, 12'habc, 40'h0, 40'h0, 40'h0);
    check(mbr & 40'hfff, 40'habc);
    do_op(OP_ADD_ADDR_HELD, 12'h5a3, 40'h0, 40'h0, 40'h0);
    check(mbr & 40'hfff, 40'h5a3);
    check(acca, lsh(40'h105f));
    for (i = 0; i < 4; i++) begin
      do_op(sops[i], 12'h000, 40'h0, 40'hc0_0000_0101 + 40'(i), L2 + 40'(i));
      check(lpr, L2 + 40'(i));
      check(lpa, (i < 2) ? lsh(L2 + 40'(i)) : rsh(L2 + 40'(i)));
      check(acca, (i < 2) ? lsh(40'hc0_0000_0101 + 40'(i)) : rsh(40'hc0_0000_0101 + 40'(i)));
    end
    do_op(OP_SUBST, 12'h060, 40'h9f_ffff_f000, 40'h0, 40'h0);
    check(mbr, 40'h9f_ffff_f000);
    do_op(OP_PRINT_SYNC, 12'h000, 40'h0, 40'h0, 40'h0);
    check(acc, WORD_ONES);
  endtask
  task automatic t_jump;
    do_op(OP_JUMP, 12'h123, 40'h0, 40'h0, 40'h0);
    check(40'(ctr), 40'h123);
    do_op(OP_JUMP_COND, 12'h456, 40'h0, 40'h0, 40'h0);
    check(40'(ctr), 40'h123);
    cond <= 1'b1;
    do_op(OP_JUMP_COND, 12'h456, 40'h0, 40'h0, 40'h0);
    cond <= 1'b0;
    check(40'(ctr), 40'h456);
  endtask
  task automatic t_load;
    do_op(OP_MUL, 12'h000, 40'h0, 40'h0, L2);
    pulse_ctl(0, 12'h100);
    stream(1'b1, OP_FETCH, 12'h000, 7'd3, 40'h11);
    check(40'(loading), 40'h1);
    check(ihr, 40'h0);
    wait_idle();
    check(40'(ctr), 40'h100);
    check(mbr, 40'h13);
    check(acc, 40'h36);
    check(lpr, L2);
    check(lpa, lsh(L2));
    check(u_rsq_mem_model.mem[12'h102], 40'h13);
  endtask
  task automatic t_drum;
    do_op(OP_FETCH, 12'h000, W1, 40'h0, 40'h0);
    sum <= 1'b1;
    stream(1'b0, OP_DRUM_IN, 12'h200, 7'd50, 40'h1000);
    sum <= 1'b0;
    check(40'(ctr), 40'h200);
    wait_idle();
    check(40'(ctr), 40'h3a5);
    check(u_rsq_mem_model.mem[12'h231], 40'h1031);
    check(mbr, 40'h1031);
    check(lpr, 40'h1031);
    check(lpa, rsh(40'h1031));
    check(acc, 40'h324c9);
    stream(1'b0, OP_TAPE_OUT, 12'h300, 7'd2, 40'h77);
    wait_idle();
    check(mbr, 40'h78);
  endtask

  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    t_fetch();
    t_arith();
    t_jump();
    t_load();
    t_drum();
    give_verdict();
  end
endmodule
`default_nettype wire
